// ===== rtl/vpr_ctrl.sv
// vcxo pull range control: register sets, tuning offset, select and recalibration
// assumes an apb master on pclk and tuning samples and select pins from outside
`timescale 1ns/100ps
// Overview of operation
// - pull scales 12.5 ppm per gain step
// - slope bit set inverts tuning direction
// - four, two or one register sets
// - set holds prescaler, integer, fraction, divider
// - select bits or pins toggle starts recalibration
// - pull equals 1.27e8/2^19 times gain/M
// - gain is six-bit binary 0 to 63, 0 gives no pull
// - scaled sample added to active fraction
// - active set is OR of bits, pins
module vpr_ctrl #(
   parameter int SET_COUNT = vpr_pkg::SET_MAX
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // asynchronous inputs
   input wire logic [vpr_pkg::TUNE_W-1:0] tuning_voltage_input,
   input wire logic [1:0] freq_set_select,
   // pll configuration
   output vpr_pkg::vpr_pll_cfg_t pll_cfg
);

   typedef struct packed {
      vpr_pkg::vpr_set_t [vpr_pkg::SET_MAX-1:0] sets;
      logic [5:0] gain;
      logic inv;
      logic [1:0] sel_reg;
      logic [1:0] sel_pin_s1;
      logic [1:0] sel_pin_s2;
      logic [vpr_pkg::TUNE_W-1:0] tune_s1;
      logic [vpr_pkg::TUNE_W-1:0] tune_s2;
      logic [1:0] sel_prev;
      logic [7:0] recal_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      vpr_pkg::vpr_pll_cfg_t cfg;
   } vpr_state_t;

   localparam logic [1:0] SET_MASK = 2'(SET_COUNT - 1);

   vpr_state_t state_ff;
   vpr_state_t nxt_state;
   logic signed [vpr_pkg::FB_W-1:0] tune_offset;

   logic [1:0] sel_comb;
   logic [1:0] active;
   logic [1:0] dec_set;
   logic dec_is_set;
   logic dec_ok;
   logic access;
   logic [31:0] rd_word;
   vpr_pkg::vpr_set_t act_set;

   vpr_tune_scale u_scale (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sample($signed(state_ff.tune_s2)),
      .gain(state_ff.gain),
      .invert(state_ff.inv),
      .offset_ff(tune_offset)
   );

   always_comb begin
      nxt_state = state_ff;
      // two-flop capture of pins and tuning sample
      nxt_state.sel_pin_s1 = freq_set_select;
      nxt_state.sel_pin_s2 = state_ff.sel_pin_s1;
      nxt_state.tune_s1 = tuning_voltage_input;
      nxt_state.tune_s2 = state_ff.tune_s1;

      sel_comb = state_ff.sel_reg | state_ff.sel_pin_s2;
      active = sel_comb & SET_MASK;
      act_set = state_ff.sets[active];

      // address decode
      dec_is_set = paddr < vpr_pkg::CTRL_OFS;
      dec_set = paddr[4:3];
      dec_ok = (paddr[1:0] == 2'h0) &&
         ((dec_is_set && ({30'h0, dec_set} < 32'(SET_COUNT))) ||
          paddr == vpr_pkg::CTRL_OFS || paddr == vpr_pkg::STATUS_OFS);
      rd_word = 32'h00000000;
      if (dec_is_set && paddr[2] == vpr_pkg::SET_DIV_BASE[2]) begin
         rd_word[vpr_pkg::DIV_PRE_LSB +: 2] = state_ff.sets[dec_set].prescaler_code;
         rd_word[vpr_pkg::DIV_OUT_LSB +: 7] = state_ff.sets[dec_set].output_divider_code;
      end else if (dec_is_set) begin
         rd_word[vpr_pkg::FB_FRAC_LSB +: 18] = state_ff.sets[dec_set].feedback_fraction_part;
         rd_word[vpr_pkg::FB_INT_LSB +: 7] = state_ff.sets[dec_set].feedback_integer_part;
      end else if (paddr == vpr_pkg::CTRL_OFS) begin
         rd_word[vpr_pkg::CTRL_GAIN_LSB +: 6] = state_ff.gain;
         rd_word[vpr_pkg::CTRL_INV_BIT] = state_ff.inv;
         rd_word[vpr_pkg::CTRL_SEL_LSB +: 2] = state_ff.sel_reg;
      end else if (paddr == vpr_pkg::STATUS_OFS) begin
         rd_word[vpr_pkg::STAT_SET_LSB +: 2] = active;
         rd_word[vpr_pkg::STAT_TUNE_LSB +: vpr_pkg::TUNE_W] = state_ff.tune_s2;
         rd_word[vpr_pkg::STAT_RECAL_LSB +: 8] = state_ff.recal_cnt;
      end

      // apb: ready one cycle into the access phase, write at completion
      access = psel && penable && state_ff.pready;
      nxt_state.pready = psel && penable && !state_ff.pready;
      if (psel && penable && !state_ff.pready) begin
         nxt_state.pslverr = !dec_ok;
         nxt_state.prdata = (!pwrite && dec_ok) ? rd_word : 32'h00000000;
      end else begin
         nxt_state.pslverr = 1'b0;
      end
      if (access && pwrite && dec_ok) begin
         if (dec_is_set && paddr[2] == vpr_pkg::SET_DIV_BASE[2]) begin
            nxt_state.sets[dec_set].prescaler_code =
               pwdata[vpr_pkg::DIV_PRE_LSB +: 2];
            nxt_state.sets[dec_set].output_divider_code =
               pwdata[vpr_pkg::DIV_OUT_LSB +: 7];
         end else if (dec_is_set) begin
            // feedback rewrites do not recalibrate; host toggles select afterwards
            nxt_state.sets[dec_set].feedback_fraction_part =
               pwdata[vpr_pkg::FB_FRAC_LSB +: 18];
            nxt_state.sets[dec_set].feedback_integer_part =
               pwdata[vpr_pkg::FB_INT_LSB +: 7];
         end else if (paddr == vpr_pkg::CTRL_OFS) begin
            nxt_state.gain = pwdata[vpr_pkg::CTRL_GAIN_LSB +: 6];
            nxt_state.inv = pwdata[vpr_pkg::CTRL_INV_BIT];
            nxt_state.sel_reg = pwdata[vpr_pkg::CTRL_SEL_LSB +: 2];
         end
      end

      // select change detection and recalibration pulse
      nxt_state.sel_prev = sel_comb;
      nxt_state.cfg.recal_start = (sel_comb != state_ff.sel_prev);
      if (sel_comb != state_ff.sel_prev) begin
         nxt_state.recal_cnt = state_ff.recal_cnt + 8'h01;
      end

      // active set drives the pll with the tuning offset added to its fraction
      nxt_state.cfg.active_set = active;
      nxt_state.cfg.prescaler_code = act_set.prescaler_code;
      nxt_state.cfg.output_divider_code = act_set.output_divider_code;
      nxt_state.cfg.feedback_word = {act_set.feedback_integer_part,
         act_set.feedback_fraction_part} + tune_offset;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= '0;
         state_ff.gain <= vpr_pkg::GAIN_RST;
         state_ff.inv <= vpr_pkg::INV_RST;
         state_ff.sel_reg <= vpr_pkg::SEL_RST;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   assign prdata = state_ff.prdata;
   assign pready = state_ff.pready;
   assign pslverr = state_ff.pslverr;
   assign pll_cfg = state_ff.cfg;

endmodule

// ===== rtl/vpr_pkg.sv
// constants, field layouts and carrier types of the vcxo pull range control
// assumes a 32-bit apb slave clocked by the pll reference
package vpr_pkg;

   // register sets, sample and feedback widths
   localparam int SET_MAX = 4;
   localparam int TUNE_W = 8;
   localparam int FB_W = 25;

   // byte offsets
   localparam logic [7:0] SET_FB_BASE = 8'h00;
   localparam logic [7:0] SET_DIV_BASE = 8'h04;
   localparam logic [7:0] SET_STRIDE = 8'h08;
   localparam logic [7:0] CTRL_OFS = 8'h20;
   localparam logic [7:0] STATUS_OFS = 8'h24;

   // field positions
   localparam int FB_FRAC_LSB = 0;
   localparam int FB_INT_LSB = 18;
   localparam int DIV_PRE_LSB = 0;
   localparam int DIV_OUT_LSB = 8;
   localparam int CTRL_GAIN_LSB = 0;
   localparam int CTRL_INV_BIT = 8;
   localparam int CTRL_SEL_LSB = 12;
   localparam int STAT_SET_LSB = 0;
   localparam int STAT_TUNE_LSB = 8;
   localparam int STAT_RECAL_LSB = 16;

   // reset values
   localparam logic [5:0] GAIN_RST = 6'h00;
   localparam logic INV_RST = 1'b0;
   localparam logic [1:0] SEL_RST = 2'h0;

   // full-scale sample times gain times 127 / 2^8 gives 63.5 lsb per gain step
   localparam logic signed [20:0] PULL_NUM = 21'sh00007F;
   localparam int PULL_SHIFT = 8;

   typedef struct packed {
      logic [1:0] prescaler_code;
      logic [6:0] feedback_integer_part;
      logic [17:0] feedback_fraction_part;
      logic [6:0] output_divider_code;
   } vpr_set_t;

   typedef struct packed {
      logic [1:0] prescaler_code;
      logic [FB_W-1:0] feedback_word;
      logic [6:0] output_divider_code;
      logic [1:0] active_set;
      logic recal_start;
   } vpr_pll_cfg_t;

endpackage

// ===== rtl/vpr_tune_scale.sv
// scales the tuning sample by gain and slope into a fractional feedback offset
// assumes sample already synchronised to pclk
`timescale 1ns/100ps
module vpr_tune_scale (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // controls
   input wire logic signed [vpr_pkg::TUNE_W-1:0] sample,
   input wire logic [5:0] gain,
   input wire logic invert,
   // result
   output logic signed [vpr_pkg::FB_W-1:0] offset_ff
);

   logic signed [20:0] prod;
   logic signed [20:0] scaled;
   logic signed [vpr_pkg::FB_W-1:0] nxt_offset;

   always_comb begin
      prod = 21'(sample) * $signed({15'h0000, gain}) * vpr_pkg::PULL_NUM;
      scaled = prod >>> vpr_pkg::PULL_SHIFT;
      if (gain == 6'h00) begin
         nxt_offset = '0;
      end else if (invert) begin
         nxt_offset = -vpr_pkg::FB_W'(scaled);
      end else begin
         nxt_offset = vpr_pkg::FB_W'(scaled);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset_ff <= '0;
      end else if (ce) begin
         offset_ff <= nxt_offset;
      end
   end

endmodule

// ===== sim/vpr_ctrl_checker.sv
// port assertions for the vcxo pull range control
// assumes ce stays high while apb traffic runs
`timescale 1ns/100ps
module vpr_ctrl_checker #(
   parameter int SET_COUNT = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // select pins and pll side
   input wire logic [1:0] freq_set_select,
   input wire vpr_pkg::vpr_pll_cfg_t pll_cfg
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_pins_still;
      $stable(freq_set_select) [*4];
   endsequence
   AST_RDY_ONE: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   AST_ERR_RDY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDY_ACCESS: assert property (pready |-> s_access)
      else $error("pready outside access phase");
   AST_RDY_LAT: assert property ($rose(penable) && psel && ce |=> pready)
      else $error("pready late");
   AST_MISALIGN: assert property (s_access and pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   AST_SET_RANGE: assert property (pll_cfg.active_set < SET_COUNT)
      else $error("active set beyond set count");
   AST_RECAL_CHG: assert property ($past(ce) |-> pll_cfg.recal_start ==
      (pll_cfg.active_set != $past(pll_cfg.active_set)))
      else $error("recal pulse not tied to select change");
   AST_PINS_SEEN: assert property (s_pins_still |->
      (pll_cfg.active_set & freq_set_select) == freq_set_select)
      else $error("select pins missing from active set");
endmodule
bind vpr_ctrl vpr_ctrl_checker #(.SET_COUNT(SET_COUNT)) i_chk (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .freq_set_select(freq_set_select), .pll_cfg(pll_cfg));

// ===== sim/vpr_apb_host.sv
// apb host model standing in for the configuration master
// assumes the slave answers with pready some cycles into the access
`timescale 1ns/100ps
module vpr_apb_host (
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hFF;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the vcxo pull range control
// assumes the apb host model drives the bus and the checker is bound
`timescale 1ns/100ps
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] tuning_voltage_input = 8'h00;
   logic [1:0] freq_set_select = 2'h0;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   vpr_pkg::vpr_pll_cfg_t pll_cfg;
   int err_count = 0;
   int tests_run = 0;
   int pulses = 0;
   always #12.5 pclk = ~pclk;
   vpr_ctrl i_vpr_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tuning_voltage_input(tuning_voltage_input),
      .freq_set_select(freq_set_select), .pll_cfg(pll_cfg));
   vpr_apb_host i_vpr_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   always @(posedge pclk) if (pll_cfg.recal_start === 1'b1) pulses++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      i_vpr_apb_host.xfer(1'b1, a, d, rd, er);
      chk({31'h0, er}, {31'h0, e});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
      i_vpr_apb_host.xfer(1'b0, a, 32'h0, rd, er);
      chk(rd, x);
      chk({31'h0, er}, {31'h0, e});
   endtask
   task automatic cfg(input logic [24:0] x);
      repeat (6) @(posedge pclk);
      chk({7'h0, pll_cfg.feedback_word}, {7'h0, x});
   endtask
   task automatic test_done();
      if (err_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge pclk);
      err_count++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      tuning_voltage_input <= 8'h40;
      @(posedge pclk);
      wr(8'h00, 32'h0057_7DE6, 1'b0);
      wr(8'h20, 32'h0000_1000, 1'b0);
      wr(8'h20, 32'h0000_0000, 1'b0);
      wr(8'h04, 32'h0000_0400, 1'b0);
      rdc(8'h00, 32'h0057_7DE6, 1'b0);
      rdc(8'h04, 32'h0000_0400, 1'b0);
      cfg(25'h0577DE6);
      wr(8'h20, 32'h0000_0008, 1'b0);
      cfg(25'h0577EE4);
      wr(8'h20, 32'h0000_0108, 1'b0);
      cfg(25'h0577CE8);
      tuning_voltage_input <= 8'h80;
      wr(8'h20, 32'h0000_003F, 1'b0);
      cfg(25'h0576E45);
      rdc(8'h20, 32'h0000_003F, 1'b0);
      wr(8'h0C, 32'h0000_7F03, 1'b0);
      wr(8'h20, 32'h0000_103F, 1'b0);
      repeat (2) @(posedge pclk);
      chk({23'h0, pll_cfg.prescaler_code, pll_cfg.output_divider_code}, 32'h0000_01FF);
      freq_set_select <= 2'h2;
      cfg(25'h1FFF05F);
      chk({30'h0, pll_cfg.active_set}, 32'h0000_0003);
      chk(pulses, 32'h0000_0004);
      rdc(8'h24, 32'h0004_8003, 1'b0);
      rdc(8'h22, 32'h0, 1'b1);
      rdc(8'h30, 32'h0, 1'b1);
      wr(8'h24, 32'hFFFF_FFFF, 1'b0);
      test_done();
   end
endmodule
